// ==== rupp_pkg.sv ====
// package for the ram user program partition register block
`default_nettype none

package rupp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  RUPP_ADDR_PROGRAM_BASE = 8'h00;  // ram_user_program_base
    localparam logic [7:0]  RUPP_ADDR_DATA_BASE    = 8'h04;  // ram_user_data_base (input copy)
    localparam logic [7:0]  RUPP_ADDR_SIZE_VALUE   = 8'h08;  // ram_size_value (input copy)
    localparam logic [7:0]  RUPP_ADDR_STATUS       = 8'h0c;  // partition check status

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int          RUPP_BASE_MSB   = 15;
    localparam int          RUPP_BASE_LSB   = 10;
    localparam int          RUPP_BASE_WIDTH = RUPP_BASE_MSB - RUPP_BASE_LSB + 1;
    localparam int          RUPP_IMPL_WIDTH = 16;
    localparam logic [RUPP_BASE_WIDTH-1:0] RUPP_BASE_RESET = 6'h00;
    localparam logic [31:0] RUPP_READ_UNMAPPED = 32'h0000_0000;

    // status bit positions
    localparam int          RUPP_STAT_ENABLED  = 0;
    localparam int          RUPP_STAT_ABOVE_DB = 1;
    localparam int          RUPP_STAT_IN_SIZE  = 2;
    localparam int          RUPP_STAT_VALID    = 3;

    // ------------------------------------------------------------
    // bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rupp_req_type;

    // partition check results
    typedef struct packed {
        logic enabled;
        logic above_data_base;
        logic within_size;
        logic valid;
    } rupp_check_type;

endpackage : rupp_pkg

`default_nettype wire

// ==== rupp_check.sv ====
// partition boundary checker for the user program base
`default_nettype none

module rupp_check
    import rupp_pkg::*;
(
    // values compared
    input  wire logic [RUPP_IMPL_WIDTH-1:0] program_base,
    input  wire logic [RUPP_IMPL_WIDTH-1:0] data_base,
    input  wire logic [RUPP_IMPL_WIDTH-1:0] size_value,
    // result
    output var rupp_check_type        result
);

    // compare against companion partition values
    always_comb begin
        result.enabled         = (program_base != '0);
        result.above_data_base = (program_base > data_base);
        result.within_size     = (program_base <= size_value);
        result.valid           = (program_base != '0) & (program_base > data_base)
                                 & (program_base <= size_value);
    end

endmodule : rupp_check

`default_nettype wire

// ==== rupp_top.sv ====
// ram user program base register with read port and partition outputs
// register map, byte offsets on the register port
// 0x00 user program base, bits 15-10 writable, rest read zero
// 0x04 read-only echo of ram_user_data_base
// 0x08 read-only echo of ram_size_value
// 0x0c partition status flags
// all other offsets read zero and ignore writes
// the base is kept in 1 KB steps in six bits of state, beside the read data, enable and valid flops
//
// timing
// a write lands on the edge that samples reg_wr; the base and
// user_program_enabled change together on that edge
// partition_valid follows one edge later, from the registered check
// reg_rdata stands for the one cycle after reg_rd, zero otherwise
//
// partition order against the companion values is a software duty;
// the block reports it in the status word and on partition_valid
// and never refuses a write that breaks it
//
// Implementation choices: the plain strobed port and the address map.
`default_nettype none

module rupp_top
    import rupp_pkg::*;
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // register port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // companion partition values
    input  wire logic [RUPP_IMPL_WIDTH-1:0] ram_user_data_base,
    input  wire logic [RUPP_IMPL_WIDTH-1:0] ram_size_value,
    // partition outputs
    output logic      [RUPP_IMPL_WIDTH-1:0] ram_user_program_base,
    output logic                            user_program_enabled,
    output logic                            partition_valid
);

    // ------------------------------------------------------------
    // request bundle
    // ------------------------------------------------------------
    // bundle the port signals once so decode reads one carrier
    rupp_req_type req;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic                       base_wr;  // write aimed at the base register
    logic [RUPP_BASE_WIDTH-1:0] wr_field; // writable slice of the write data

    // true when a request names the given register offset
    function automatic logic addr_hit(
        input rupp_req_type r,
        input logic [7:0]   a
    );
        return (r.addr == a);
    endfunction : addr_hit

    // only the program base offset takes writes
    assign base_wr  = req.wr && addr_hit(req, RUPP_ADDR_PROGRAM_BASE);
    // bits outside 15-10 never reach the register
    assign wr_field = req.wdata[RUPP_BASE_MSB:RUPP_BASE_LSB];

    // ------------------------------------------------------------
    // word builders
    // ------------------------------------------------------------
    // form a full 32-bit view of the implemented base
    function automatic logic [31:0] base_word(input logic [RUPP_BASE_WIDTH-1:0] b);
        logic [31:0] w;
        w = '0;
        w[RUPP_BASE_MSB:RUPP_BASE_LSB] = b;
        return w;
    endfunction : base_word

    // widen a companion value, the unimplemented upper half reads zero
    function automatic logic [31:0] echo_word(input logic [RUPP_IMPL_WIDTH-1:0] v);
        logic [31:0] w;
        w = '0;
        w[RUPP_IMPL_WIDTH-1:0] = v;
        return w;
    endfunction : echo_word

    // pack the check flags into the low bits of the status word
    function automatic logic [31:0] status_word(input rupp_check_type c);
        logic [31:0] w;
        w = '0;
        w[RUPP_STAT_ENABLED]  = c.enabled;
        w[RUPP_STAT_ABOVE_DB] = c.above_data_base;
        w[RUPP_STAT_IN_SIZE]  = c.within_size;
        w[RUPP_STAT_VALID]    = c.valid;
        return w;
    endfunction : status_word

    // ------------------------------------------------------------
    // base register
    // ------------------------------------------------------------
    // six writable bits hold the base; read data, enable and valid have flops of their own
    logic [RUPP_BASE_WIDTH-1:0] base_q;
    logic [RUPP_BASE_WIDTH-1:0] base_d;

    // write takes only bits 15-10
    always_comb begin
        base_d = base_q;
        // hold unless a base write is taken
        if (base_wr) begin
            base_d = wr_field;
        end
    end

    // register the base
    // the clear also hands all RAM back to kernel data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            base_q <= RUPP_BASE_RESET;
        end else begin
            base_q <= base_d;
        end
    end

    // ------------------------------------------------------------
    // partition check
    // ------------------------------------------------------------
    logic [31:0]    base_full;
    rupp_check_type chk;

    // software view of the base, low ten bits forced to zero
    assign base_full = base_word(base_q);

    // compare the live base against the companion values
    rupp_check u_check (
        .program_base (base_full[RUPP_IMPL_WIDTH-1:0]),
        .data_base    (ram_user_data_base),
        .size_value   (ram_size_value),
        .result       (chk)
    );

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // read data register and its next value
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // candidate read words, one per mapped register
    logic [31:0] word_base;
    logic [31:0] word_dbase;
    logic [31:0] word_size;
    logic [31:0] word_status;

    // build each word once, picked below by the read offset
    assign word_base   = base_full;
    assign word_dbase  = echo_word(ram_user_data_base);
    assign word_size   = echo_word(ram_size_value);
    assign word_status = status_word(chk);

    // select read word, unmapped reads zero
    // idle cycles give zero so a stale word never looks like an answer
    always_comb begin
        rdata_d = '0;
        if (req.rd) begin
            case (req.addr)
                RUPP_ADDR_PROGRAM_BASE: rdata_d = word_base;
                RUPP_ADDR_DATA_BASE:    rdata_d = word_dbase;
                RUPP_ADDR_SIZE_VALUE:   rdata_d = word_size;
                RUPP_ADDR_STATUS:       rdata_d = word_status;
                default:                rdata_d = RUPP_READ_UNMAPPED;
            endcase
        end
    end

    // register read data for one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // registered copies of the partition state
    logic en_q;
    logic en_d;
    logic valid_q;
    logic valid_d;

    // base zero means all RAM to kernel data
    // taken from base_d so the flag moves on the same edge as the base
    always_comb begin
        en_d    = (base_d != RUPP_BASE_RESET);
        valid_d = chk.valid;
    end

    // register the partition outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_q    <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            en_q    <= en_d;
            valid_q <= valid_d;
        end
    end

    // every data output comes straight from a flop
    assign reg_rdata             = rdata_q;
    assign ram_user_program_base = base_full[RUPP_IMPL_WIDTH-1:0];
    assign user_program_enabled  = en_q;
    assign partition_valid       = valid_q;

endmodule : rupp_top

`default_nettype wire

// ==== rupp_checker.sv ====
// assertion checker for the ram user program base register
`default_nettype none
module rupp_checker
    import rupp_pkg::*;
(
    // bus side
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // partition side
    input wire logic [15:0] ram_user_program_base,
    input wire logic        user_program_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // write decode and writable slice
    logic [5:0] wr_bits;
    logic       base_wr;
    assign wr_bits = reg_wdata[15:10];
    assign base_wr = reg_wr && reg_addr == RUPP_ADDR_PROGRAM_BASE;
    AST_READ_UPPER: assert property (reg_rd |=> reg_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_ENABLE: assert property (user_program_enabled == (ram_user_program_base != 16'h0000))
        else $error("enable does not follow base");
    AST_LOW_ZERO: assert property (ram_user_program_base[9:0] == 10'h000)
        else $error("low base bits not zero");
    AST_RESET: assert property ($fell(rst) |-> ram_user_program_base == 16'h0000)
        else $error("base not clear after reset");
    AST_WRITE: assert property (base_wr |=> ram_user_program_base == {$past(wr_bits), 10'h000})
        else $error("base write wrong");
    AST_HOLD: assert property (!base_wr |=> $stable(ram_user_program_base))
        else $error("base changed without write");
endmodule : rupp_checker
`default_nettype wire

// ==== tb_rupp_top.sv ====
// testbench for the ram user program base register
`default_nettype none
module tb_rupp_top
    import rupp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        en;
    logic        valid;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic [15:0] dbase = 16'h0400;
    logic [15:0] size = 16'h8000;
    logic [15:0] base;
    int          miscompares = 0;
    int          check_count = 0;
    always #4 clock = ~clock;
    rupp_top i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_user_data_base(dbase),
        .ram_size_value(size), .ram_user_program_base(base), .user_program_enabled(en),
        .partition_valid(valid));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // write base, let status settle, check enable and valid
    task automatic part(input logic [31:0] d, input logic [1:0] exp);
        wr(RUPP_ADDR_PROGRAM_BASE, d);
        repeat (2) @(posedge clock);
        #1 chk({30'h0, en, valid}, {30'h0, exp});
    endtask : part
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // reset value, write mask, unmapped offsets and companion echoes
    task automatic test_register;
        rd(RUPP_ADDR_PROGRAM_BASE, 32'h0000_0000);
        chk({15'h0, en, base}, 32'h0);
        wr(RUPP_ADDR_PROGRAM_BASE, 32'hffff_ffff);
        rd(RUPP_ADDR_PROGRAM_BASE, 32'h0000_fc00);
        wr(8'h10, 32'h0000_0400);
        rd(RUPP_ADDR_PROGRAM_BASE, 32'h0000_fc00);
        rd(8'h10, 32'h0000_0000);
        rd(RUPP_ADDR_DATA_BASE, {16'h0000, dbase});
        rd(RUPP_ADDR_SIZE_VALUE, {16'h0000, size});
        $display("test register done");
    endtask : test_register
    // partition outputs and status word against the companion values
    task automatic test_partition;
        part(32'h0000_0800, 2'b11);
        rd(RUPP_ADDR_STATUS, 32'h0000_000f);
        part(32'h0000_0400, 2'b10);
        rd(RUPP_ADDR_STATUS, 32'h0000_0005);
        part(32'h0000_fc00, 2'b10);
        rd(RUPP_ADDR_STATUS, 32'h0000_0003);
        part(32'h0000_03ff, 2'b00);
        rd(RUPP_ADDR_STATUS, 32'h0000_0004);
        $display("test partition done");
    endtask : test_partition
    // mid-run reset clears a valid partition
    task automatic test_reset;
        wr(RUPP_ADDR_PROGRAM_BASE, 32'h0000_0c00);
        rd(RUPP_ADDR_PROGRAM_BASE, 32'h0000_0c00);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        rd(RUPP_ADDR_PROGRAM_BASE, 32'h0000_0000);
        chk({30'h0, en, valid}, 32'h0);
        $display("test reset done");
    endtask : test_reset
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        test_register();
        test_partition();
        test_reset();
        end_of_test();
    end
endmodule : tb_rupp_top
bind rupp_top rupp_checker i_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ram_user_program_base(ram_user_program_base), .user_program_enabled(user_program_enabled));
`default_nettype wire
